/* File: design/tuner_pkg.sv */
/*
 * shared constants and state types for the tuner serial port ends.
 * assumes both ends run on one 100 MHz clock and meet in tuner_link_if.
 */
package tuner_pkg;
  // ==========================================================
  // link framing
  localparam logic [3:0] CHIP3 = 4'h6;
  localparam logic [6:0] DEV_ADDR2 = 7'h10;
  localparam logic [4:0] WR_START = 5'h04;
  localparam logic [4:0] RD_START = 5'h14;
  localparam logic [4:0] CTL_BITS = 5'h09;
  localparam logic [4:0] X3_LAST = 5'h18;
  localparam logic [4:0] X3_END = 5'h19;
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // ==========================================================
  // synchroniser bit positions (device side)
  localparam int P_SCLK = 0;
  localparam int P_SDIO = 1;
  localparam int P_SEL = 2;
  localparam int P_GP1 = 3;
  localparam int P_GP3 = 4;
  localparam int P_RSTN = 5;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int REF_HZ = 32768;
  localparam int REF_HALF = CLK_HZ / (2 * REF_HZ);
  localparam int SCLK_HALF = 8;
  // ==========================================================
  // controller register map
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_WDATA = 8'h08;
  localparam logic [7:0] A_RDATA = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam int CFG_HOLD = 0;
  localparam int CFG_M2 = 1;
  localparam int CFG_TWO = 2;
  localparam int CFG_REF = 3;
  localparam logic [3:0] CFG_RST = 4'h1;
  localparam int CMD_RD = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_NACK = 2;
  // ==========================================================
  // state types
  typedef enum logic [2:0] {
    D_IDLE = 3'h0, D_RECV = 3'h1, D_ACK1 = 3'h3, D_ACK2 = 3'h2,
    D_SEND = 3'h6, D_RACK = 3'h7, D_X3 = 3'h4
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_X3 = 3'h1, H_START = 3'h3, H_BIT = 3'h2,
    H_STOP = 3'h6
  } host_state_t;
endpackage : tuner_pkg

/* File: design/tuner_link_if.sv */
/*
 * pins between the controller and the tuner port.
 * assumes a pull-up on sclk and sdio; an enable low drives the pin.
 */
`timescale 1ns/100ps
interface tuner_link_if;
  logic h_sclk;
  logic h_sclk_oe;
  logic h_sdio;
  logic h_sdio_oe;
  logic d_sdio;
  logic d_sdio_oe;
  logic serial_select_n;
  logic general_pin_one;
  logic general_pin_three;
  logic tuner_rst_n;
  logic ref_clk;
  logic sclk;
  logic sdio;
  // ==========================================================
  // wired levels, pulled high when nobody pulls low
  assign sclk = h_sclk_oe | h_sclk;
  assign sdio = (h_sdio_oe | h_sdio) & (d_sdio_oe | d_sdio);
  modport host (
    output h_sclk, h_sclk_oe, h_sdio, h_sdio_oe, serial_select_n,
    output general_pin_one, general_pin_three, tuner_rst_n, ref_clk,
    input sclk, sdio
  );
  modport device (
    output d_sdio, d_sdio_oe,
    input sclk, sdio, serial_select_n, general_pin_one,
    input general_pin_three, tuner_rst_n, ref_clk
  );
endinterface : tuner_link_if

/* File: design/tuner_port.sv */
/*
 * tuner end: register file reached over the three-wire or two-wire link.
 * assumes link pins are asynchronous; all but ref_clk are synchronised here.
 */
//
// Overview of operation
// - select low at sclk rise starts frame
// - nine-bit word: chip 0110, r/w, register
// - order A7:A5, r/w, then A4:A0
// - write: sixteen data bits on rises
// - read: half-cycle turnaround, sixteen bits out
// - select high ends frame; 26 cycles
// - two-wire pins only pulled low
// - START then address 0010000 plus r/w
// - ack address low one cycle
// - ack each written byte likewise
// - writes start 02h high, wrap to 00h
// - STOP ends transfer, resets byte pointer
// - reads start 0Ah high, wrap to 00h
// - controller acks to request more bytes
// - reset low clears registers, idles bus
// - method one: pin three, sdio low
// - method one: select high means two-wire
// - method two: pin one high means two-wire
// - controller supplies reference clock when enabled
// - register access needs no reference clock
// - oscillator changes only while powered down
// - keep bus quiet during seek or tune
// - sclk high from reset edge to START
`timescale 1ns/100ps
module tuner_port (
  input wire logic clk_i,
  input wire logic rst_i,
  tuner_link_if.device link,
  output logic two_wire_o,
  output logic power_enable_o,
  output logic reg_wr_o,
  output logic [3:0] reg_addr_o,
  output logic [15:0] reg_data_o
);
  typedef struct packed {
    logic [5:0] p1;
    logic [5:0] p2;
    logic [5:0] p3;
    logic two_wire;
    tuner_pkg::dev_state_t st;
    logic [4:0] cnt;
    logic [8:0] ctl;
    logic [15:0] sh;
    logic rw;
    logic is_addr;
    logic [4:0] ptr;
    logic sdio_o;
    logic sdio_oe;
    logic wr;
    logic [3:0] wa;
    logic [15:0] wd;
    logic [15:0][15:0] regs;
  } dev_t;

  dev_t q;
  dev_t d;
  logic rise;
  logic fall;
  logic bit_in;
  logic sel_n;
  logic start_c;
  logic stop_c;
  logic match3;
  logic [7:0] rd_byte;
  logic [7:0] rx_byte;
  logic [3:0] a3;

  // ==========================================================
  // edges and conditions, from second and third stages only
  assign rise = q.p2[tuner_pkg::P_SCLK] & ~q.p3[tuner_pkg::P_SCLK];
  assign fall = ~q.p2[tuner_pkg::P_SCLK] & q.p3[tuner_pkg::P_SCLK];
  assign bit_in = q.p2[tuner_pkg::P_SDIO];
  assign sel_n = q.p2[tuner_pkg::P_SEL];
  // both sclk samples high, so a data change at a clock fall is no START
  assign start_c = q.p2[tuner_pkg::P_SCLK] & q.p3[tuner_pkg::P_SCLK]
    & q.p3[tuner_pkg::P_SDIO] & ~bit_in;
  assign stop_c = q.p2[tuner_pkg::P_SCLK] & q.p3[tuner_pkg::P_SCLK]
    & ~q.p3[tuner_pkg::P_SDIO] & bit_in;
  assign match3 = {q.ctl[8:6], q.ctl[4]} == tuner_pkg::CHIP3;
  assign a3 = q.ctl[3:0];
  assign rd_byte = q.ptr[0] ? q.regs[q.ptr[4:1]][7:0]
                            : q.regs[q.ptr[4:1]][15:8];
  assign rx_byte = {q.sh[6:0], bit_in};

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.wr = 1'b0;
    d.p1 = {link.tuner_rst_n, link.general_pin_three,
            link.general_pin_one, link.serial_select_n, link.sdio,
            link.sclk};
    d.p2 = q.p1;
    d.p3 = q.p2;
    if (rst_i || !q.p2[tuner_pkg::P_RSTN]) begin
      d.st = tuner_pkg::D_IDLE;
      d.regs = {16{tuner_pkg::REG_RESET}};
      d.sdio_oe = 1'b1;
      d.sdio_o = 1'b0;
      d.ptr = tuner_pkg::WR_START;
      d.cnt = '0;
      if (rst_i) begin
        d.two_wire = 1'b0;
      end
    end else if (!q.p3[tuner_pkg::P_RSTN]) begin
      // straps as they stood just before release
      d.two_wire = q.p3[tuner_pkg::P_GP3] ? q.p3[tuner_pkg::P_GP1]
                                          : q.p3[tuner_pkg::P_SEL];
    end else if (!q.two_wire) begin
      // only sclk paces the port, reference clock unused
      if (rise) begin
        if (q.st != tuner_pkg::D_X3) begin
          if (!sel_n) begin
            d.st = tuner_pkg::D_X3;
            d.ctl = {q.ctl[7:0], bit_in};
            d.cnt = 5'h01;
          end
        end else if (sel_n) begin
          // end on rise with select high
          d.st = tuner_pkg::D_IDLE;
          d.sdio_oe = 1'b1;
        end else begin
          if (q.cnt < tuner_pkg::CTL_BITS) begin
            d.ctl = {q.ctl[7:0], bit_in};
          end else if (match3 && q.ctl[5]) begin
            // drive read bits on rises after turnaround
            if (q.cnt <= tuner_pkg::X3_LAST) begin
              d.sdio_oe = 1'b0;
              d.sdio_o = q.regs[a3][4'(tuner_pkg::X3_LAST - q.cnt)];
            end else begin
              d.sdio_oe = 1'b1;
            end
          end else if (match3 && q.cnt <= tuner_pkg::X3_LAST) begin
            d.sh = {q.sh[14:0], bit_in};
            if (q.cnt == tuner_pkg::X3_LAST) begin
              d.regs[a3] = {q.sh[14:0], bit_in};
              d.wr = 1'b1;
              d.wa = a3;
              d.wd = {q.sh[14:0], bit_in};
            end
          end
          // count saturates, a running clock is harmless
          if (q.cnt != tuner_pkg::X3_END) begin
            d.cnt = q.cnt + 5'h01;
          end
        end
      end
    end else if (stop_c) begin
      d.st = tuner_pkg::D_IDLE;
      d.sdio_oe = 1'b1;
      d.ptr = tuner_pkg::WR_START;
    end else if (start_c) begin
      d.st = tuner_pkg::D_RECV;
      d.cnt = '0;
      d.is_addr = 1'b1;
      d.sdio_oe = 1'b1;
    end else begin
      case (q.st)
        tuner_pkg::D_RECV: begin
          if (rise) begin
            d.sh = {q.sh[14:0], bit_in};
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == tuner_pkg::BYTE_LAST) begin
              d.st = tuner_pkg::D_ACK1;
              if (q.is_addr) begin
                // address compare, stay silent on mismatch
                if (rx_byte[7:1] != tuner_pkg::DEV_ADDR2) begin
                  d.st = tuner_pkg::D_IDLE;
                end
                d.rw = rx_byte[0];
                d.ptr = rx_byte[0] ? tuner_pkg::RD_START
                                   : tuner_pkg::WR_START;
              end else begin
                // byte written, pointer wraps at 0Fh low
                if (q.ptr[0]) begin
                  d.regs[q.ptr[4:1]][7:0] = rx_byte;
                end else begin
                  d.regs[q.ptr[4:1]][15:8] = rx_byte;
                end
                d.wr = 1'b1;
                d.wa = q.ptr[4:1];
                d.wd = d.regs[q.ptr[4:1]];
                d.ptr = q.ptr + 5'h01;
              end
            end
          end
        end
        tuner_pkg::D_ACK1: begin
          // ack by pulling low after the fall
          if (fall) begin
            d.sdio_o = 1'b0;
            d.sdio_oe = 1'b0;
            d.st = tuner_pkg::D_ACK2;
          end
        end
        tuner_pkg::D_ACK2: begin
          if (fall) begin
            d.sdio_oe = 1'b1;
            d.is_addr = 1'b0;
            d.cnt = '0;
            d.st = tuner_pkg::D_RECV;
            if (q.rw) begin
              // first bit out on the fall
              d.sdio_oe = rd_byte[7];
              d.cnt = 5'h01;
              d.st = tuner_pkg::D_SEND;
            end
          end
        end
        tuner_pkg::D_SEND: begin
          if (fall) begin
            if (q.cnt == tuner_pkg::BYTE_BITS) begin
              d.sdio_oe = 1'b1;
              d.ptr = q.ptr + 5'h01;
              d.st = tuner_pkg::D_RACK;
            end else begin
              // a one bit is a released line
              d.sdio_oe = rd_byte[3'(tuner_pkg::BYTE_LAST - q.cnt)];
              d.cnt = q.cnt + 5'h01;
            end
          end
        end
        tuner_pkg::D_RACK: begin
          // low means another byte, high waits for STOP
          if (rise) begin
            d.st = bit_in ? tuner_pkg::D_IDLE : tuner_pkg::D_ACK2;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // ==========================================================
  // outputs
  assign link.d_sdio = q.sdio_o;
  assign link.d_sdio_oe = q.sdio_oe;
  assign two_wire_o = q.two_wire;
  assign power_enable_o = q.regs[2][0];
  assign reg_wr_o = q.wr;
  assign reg_addr_o = q.wa;
  assign reg_data_o = q.wd;
endmodule : tuner_port

/* File: design/tuner_ctrl.sv */
/*
 * controller end: wishbone registers drive straps, reset and transfers.
 * assumes a classic wishbone master on clk_i; the link pins are async.
 */
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module tuner_ctrl #(
  parameter int HALF = tuner_pkg::SCLK_HALF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  tuner_link_if.host link
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [3:0] cfg;
    logic [9:0] cmd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    logic nack;
    tuner_pkg::host_state_t st;
    logic [7:0] div;
    logic tick;
    logic [4:0] r;
    logic [4:0] b;
    logic [4:0] n;
    logic sclk;
    logic sclk_oe;
    logic sdio_oe;
    logic sel_n;
    logic rstn;
    logic rclk;
    logic [10:0] rdiv;
    logic ack;
    logic [31:0] dat;
  } host_t;

  host_t q;
  host_t d;
  logic busy;
  logic rd;
  logic req;
  logic last_ack;
  logic stop_now;
  logic [4:0] cnt;
  logic [4:0] nx;
  logic [4:0] nn;
  logic [4:0] nb;
  logic [7:0] ctl2;
  logic [7:0] nbyte;
  logic [24:0] w3;
  logic hi;
  logic [4:0] x3_idx;

  assign busy = q.st != tuner_pkg::H_IDLE;
  assign rd = q.cmd[tuner_pkg::CMD_RD];
  assign cnt = q.cmd[9:5];
  assign req = wb_cyc_i & wb_stb_i & ~q.ack;
  // wire order: A7:A5, r/w, A4:A0, data
  assign w3 = {tuner_pkg::CHIP3[3:1], rd, tuner_pkg::CHIP3[0],
               q.cmd[3:0], q.wdata};
  // a plain net, so the frame bit follows r on every change
  assign x3_idx = (q.r <= tuner_pkg::X3_LAST) ? tuner_pkg::X3_LAST - q.r
                                               : '0;
  assign nx = q.r + 5'h01;
  assign ctl2 = {tuner_pkg::DEV_ADDR2, rd};
  assign last_ack = q.b == tuner_pkg::BYTE_BITS;
  assign nn = last_ack ? q.n + 5'h01 : q.n;
  assign nb = last_ack ? '0 : q.b + 5'h01;
  assign nbyte = (nn == '0) ? ctl2 : (nn[0] ? q.wdata[15:8]
                                            : q.wdata[7:0]);
  // ack while more bytes are wanted; release for data reads
  assign hi = (nb == tuner_pkg::BYTE_BITS)
    ? ((nn == '0 || !rd) || nn == cnt)
    : ((nn != '0 && rd) || nbyte[3'(tuner_pkg::BYTE_LAST - nb)]);
  assign stop_now = last_ack &&
    (((q.n == '0 || !rd) && q.s2) || q.n == cnt);

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.s1 = link.sdio;
    d.s2 = q.s1;
    d.ack = req;
    d.tick = 1'b0;
    // ========================================================
    // wishbone slave, answers the cycle after a request
    if (req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == tuner_pkg::A_CFG) begin
        d.cfg = wb_dat_i[3:0];
      end else if (wb_adr_i == tuner_pkg::A_CMD) begin
        // refused while busy or while the tuner is held
        if (!busy && !q.cfg[tuner_pkg::CFG_HOLD]) begin
          d.cmd = wb_dat_i[9:0];
          d.done = 1'b0;
          d.nack = 1'b0;
          d.div = '0;
          d.r = '0;
          if (q.cfg[tuner_pkg::CFG_TWO]) begin
            d.st = tuner_pkg::H_START;
          end else begin
            // select low with first bit ready
            d.st = tuner_pkg::H_X3;
            d.sel_n = 1'b0;
            d.sclk = 1'b0;
            d.sclk_oe = 1'b0;
            d.sdio_oe = 1'b0;
          end
        end
      end else if (wb_adr_i == tuner_pkg::A_WDATA) begin
        d.wdata[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) begin
          d.wdata[15:8] = wb_dat_i[15:8];
        end
      end else if (wb_adr_i == tuner_pkg::A_STAT) begin
        if (wb_dat_i[tuner_pkg::STAT_DONE]) begin
          d.done = 1'b0;
        end
      end
    end
    if (wb_adr_i == tuner_pkg::A_CFG) begin
      d.dat = 32'(q.cfg);
    end else if (wb_adr_i == tuner_pkg::A_CMD) begin
      d.dat = 32'(q.cmd);
    end else if (wb_adr_i == tuner_pkg::A_WDATA) begin
      d.dat = 32'(q.wdata);
    end else if (wb_adr_i == tuner_pkg::A_RDATA) begin
      d.dat = 32'(q.rdata);
    end else if (wb_adr_i == tuner_pkg::A_STAT) begin
      d.dat = 32'({q.nack, q.done, busy});
    end else begin
      d.dat = '0;
    end
    // ========================================================
    // reference clock while enabled
    if (q.cfg[tuner_pkg::CFG_REF]) begin
      if (q.rdiv == 11'(tuner_pkg::REF_HALF - 1)) begin
        d.rdiv = '0;
        d.rclk = ~q.rclk;
      end else begin
        d.rdiv = q.rdiv + 11'h001;
      end
    end else begin
      d.rdiv = '0;
      d.rclk = 1'b0;
    end
    // ========================================================
    // half-period divider for sclk
    if (busy) begin
      if (q.div == 8'(HALF - 1)) begin
        d.div = '0;
        d.tick = 1'b1;
      end else begin
        d.div = q.div + 8'h01;
      end
    end
    if (q.cfg[tuner_pkg::CFG_HOLD]) begin
      // straps held while reset is low; sel_n and sdio_oe go high in the release cycle
      d.st = tuner_pkg::H_IDLE;
      d.rstn = 1'b0;
      d.sel_n = q.cfg[tuner_pkg::CFG_M2] | q.cfg[tuner_pkg::CFG_TWO];
      d.sdio_oe = q.cfg[tuner_pkg::CFG_M2];
      d.sclk = q.cfg[tuner_pkg::CFG_TWO];
      d.sclk_oe = q.cfg[tuner_pkg::CFG_TWO];
    end else if (!busy) begin
      d.rstn = 1'b1;
      if (d.st == tuner_pkg::H_IDLE) begin
        d.sel_n = 1'b1;
        d.sdio_oe = 1'b1;
        d.sclk = q.cfg[tuner_pkg::CFG_TWO];
        d.sclk_oe = q.cfg[tuner_pkg::CFG_TWO];
      end
    end else if (q.tick) begin
      case (q.st)
        tuner_pkg::H_X3: begin
          if (!q.sclk) begin
            d.sclk = 1'b1;
          end else begin
            d.sclk = 1'b0;
            d.r = nx;
            if (rd && q.r >= tuner_pkg::CTL_BITS &&
                q.r <= tuner_pkg::X3_LAST) begin
              d.rdata = {q.rdata[14:0], q.s2};
            end
            // select high before the closing rise
            if (q.r == tuner_pkg::X3_LAST) begin
              d.sel_n = 1'b1;
            end
            if (q.r == tuner_pkg::X3_END) begin
              d.st = tuner_pkg::H_IDLE;
              d.done = 1'b1;
            end
            // write bits set up on falls, released for reads
            if (nx <= tuner_pkg::X3_LAST &&
                !(rd && nx >= tuner_pkg::CTL_BITS)) begin
              d.sdio_oe = 1'b0;
            end else begin
              d.sdio_oe = 1'b1;
            end
          end
        end
        tuner_pkg::H_START: begin
          // data falls while sclk is high
          d.r = nx;
          d.sdio_oe = 1'b0;
          if (q.r != '0) begin
            d.sclk = 1'b0;
            d.sclk_oe = 1'b0;
            d.sdio_oe = ctl2[7];
            d.b = '0;
            d.n = '0;
            d.st = tuner_pkg::H_BIT;
          end
        end
        tuner_pkg::H_BIT: begin
          if (!q.sclk) begin
            d.sclk = 1'b1;
            d.sclk_oe = 1'b1;
          end else begin
            d.sclk = 1'b0;
            d.sclk_oe = 1'b0;
            if (!last_ack && q.n != '0 && rd) begin
              d.rdata = {q.rdata[14:0], q.s2};
            end
            if (last_ack && (q.n == '0 || !rd) && q.s2) begin
              d.nack = 1'b1;
            end
            if (stop_now) begin
              d.sdio_oe = 1'b0;
              d.r = '0;
              d.st = tuner_pkg::H_STOP;
            end else begin
              // open drain, one is a released line
              d.sdio_oe = hi;
              d.b = nb;
              d.n = nn;
            end
          end
        end
        tuner_pkg::H_STOP: begin
          // data rises while sclk is high
          d.r = nx;
          d.sclk = 1'b1;
          d.sclk_oe = 1'b1;
          if (q.r != '0) begin
            d.sdio_oe = 1'b1;
            d.st = tuner_pkg::H_IDLE;
            d.done = 1'b1;
          end
        end
        default: begin
          d.st = tuner_pkg::H_IDLE;
        end
      endcase
    end
    if (rst_i) begin
      d = '0;
      d.cfg = tuner_pkg::CFG_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // ==========================================================
  // outputs; three-wire data comes from the frame word directly
  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign link.h_sclk = q.sclk;
  assign link.h_sclk_oe = q.sclk_oe;
  assign link.h_sdio = (q.st == tuner_pkg::H_X3) & w3[x3_idx];
  assign link.h_sdio_oe = q.sdio_oe;
  assign link.serial_select_n = q.sel_n;
  assign link.general_pin_one = q.cfg[tuner_pkg::CFG_TWO];
  assign link.general_pin_three = q.cfg[tuner_pkg::CFG_M2];
  assign link.tuner_rst_n = q.rstn;
  assign link.ref_clk = q.rclk;
endmodule : tuner_ctrl

/* File: tb/tuner_link_asserts.sv */
/* checker for the tuner link pins.
   assumes one clock for both ends; tb_top instances it beside the link. */
`timescale 1ns/100ps
module tuner_link_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic h_sclk,
  input wire logic h_sclk_oe,
  input wire logic d_sdio,
  input wire logic d_sdio_oe,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic general_pin_one,
  input wire logic general_pin_three,
  input wire logic tuner_rst_n
);
  // ==========================================================
  // helpers: sclk rises in frame, select high time, strapped mode
  // straps count as they stood at the last low sample of reset
  logic sclk_q, rst_n_q, two_q, strap_q;
  logic [4:0] rise_q, hi_q;
  always_ff @(posedge clk_i) begin
    sclk_q <= sclk;
    rst_n_q <= tuner_rst_n;
    if (rst_i || serial_select_n) rise_q <= 5'h00;
    else if (sclk && !sclk_q) rise_q <= rise_q + 5'h01;
    if (rst_i || !serial_select_n) hi_q <= 5'h00;
    else if (hi_q != 5'h1F) hi_q <= hi_q + 5'h01;
    strap_q <= general_pin_three ? general_pin_one : serial_select_n;
    if (rst_i) two_q <= 1'b0;
    else if (tuner_rst_n && !rst_n_q)
      two_q <= strap_q;
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_frame_len: assert property (
    !two_q && $rose(serial_select_n) && rise_q != 5'h00 |-> rise_q == 5'h19)
    else $error("three-wire frame length wrong");
  chk_word_quiet: assert property (
    tuner_rst_n && !two_q && !serial_select_n && rise_q < 5'h09 |-> d_sdio_oe)
    else $error("tuner drove sdio in control word");
  chk_frame_free: assert property (
    tuner_rst_n && !two_q && hi_q == 5'h14 |-> d_sdio_oe)
    else $error("tuner kept sdio after frame");
  chk_bit_steady: assert property (
    tuner_rst_n && !two_q && !d_sdio_oe && $fell(sclk)
    |-> $stable(d_sdio) && d_sdio == $past(d_sdio, 2))
    else $error("read bit moved at capture");
  chk_host_od: assert property (
    tuner_rst_n && two_q && !h_sclk_oe |-> !h_sclk)
    else $error("controller drove sclk high");
  chk_dev_od: assert property (
    two_q && !d_sdio_oe |-> !d_sdio)
    else $error("tuner drove sdio high");
  chk_change_low: assert property (
    tuner_rst_n && two_q && $changed(d_sdio_oe) |-> !sclk)
    else $error("tuner moved sdio with sclk high");
  chk_ack_held: assert property (
    two_q && $rose(sclk) && !d_sdio_oe |=> !d_sdio_oe [*4])
    else $error("ack dropped in high phase");
  chk_reset_quiet: assert property (
    !tuner_rst_n [*4] |-> d_sdio_oe)
    else $error("tuner drove sdio in reset");
endmodule : tuner_link_asserts

/* File: tb/tb_top.sv */
/* tb_top: both tuner ends joined, driven over wishbone.
   assumes HALF of 8, so a 160 ns link clock. */
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, q;
  logic ack, two, pe, wr;
  logic [3:0] ra, la, m;
  logic [15:0] rd, ld, v;
  logic [3:0] modes [4] = '{4'h0, 4'hA, 4'h4, 4'h6};
  int failures = 0;
  int n_checks = 0;
  int n_wr = 0;
  int n;
  tuner_link_if link ();
  always #5 clk_i = ~clk_i;
  tuner_ctrl #(.HALF(8)) u_tuner_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link(link.host));
  tuner_port u_tuner_port (.clk_i(clk_i), .rst_i(rst_i),
    .link(link.device), .two_wire_o(two), .power_enable_o(pe),
    .reg_wr_o(wr), .reg_addr_o(ra), .reg_data_o(rd));
  tuner_link_asserts u_tuner_link_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .h_sclk(link.h_sclk), .h_sclk_oe(link.h_sclk_oe), .d_sdio(link.d_sdio),
    .d_sdio_oe(link.d_sdio_oe), .sclk(link.sclk),
    .serial_select_n(link.serial_select_n),
    .general_pin_one(link.general_pin_one),
    .general_pin_three(link.general_pin_three),
    .tuner_rst_n(link.tuner_rst_n));
  // ==========================================================
  // register update monitor
  always @(posedge clk_i) begin
    if (wr === 1'b1) begin
      la <= ra;
      ld <= rd;
      n_wr <= n_wr + 1;
    end
  end
  // ==========================================================
  // bus tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k == 50) begin
      failures++;
      $display("mismatch at %0t: no ack from wishbone", $time);
    end
    q = rdat;
    cyc <= 1'b0;
  endtask : xfer
  // status polled over wishbone only, the link stays quiet
  // a stuck done bit ends at the limit
  task automatic run(input logic [31:0] c);
    int k;
    k = 0;
    xfer(8'h04, 1'b1, c);
    do begin
      xfer(8'h10, 1'b0, 32'h0);
      k++;
    end while (q[1] !== 1'b1 && k < 3000);
    cmp(q & 32'h7, 32'h2);
    xfer(8'h10, 1'b1, 32'h2);
  endtask : run
  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // ==========================================================
  // tests
  initial begin
    #800000;
    failures++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(8'h00, 1'b0, 32'h0);
    cmp(q, 32'h1);
    xfer(8'h20, 1'b0, 32'h0);
    cmp(q, 32'h0);
    $display("reset test done");
    foreach (modes[i]) begin
      m = modes[i];
      v = {m, 12'h3C5};
      xfer(8'h00, 1'b1, {28'h0, m | 4'h1}); // straps held in reset
      repeat (8) @(posedge clk_i);
      xfer(8'h00, 1'b1, {28'h0, m});
      repeat (8) @(posedge clk_i);
      cmp(two, m[2]);
      cmp(pe, 1'b0);
      xfer(8'h08, 1'b1, {16'h0, v});
      run(m[2] ? 32'h240 : 32'h00A);
      cmp(la, 4'hA);
      cmp(ld, v);
      cmp(pe, m[2]);
      run(m[2] ? 32'h050 : 32'h01A);
      xfer(8'h0C, 1'b0, 32'h0);
      cmp(q, {16'h0, v});
      $display("mode %h test done", m);
    end
    xfer(8'h08, 1'b1, 32'h0100);
    n = n_wr;
    run(32'h3C0);
    cmp(n_wr - n, 30);
    cmp(la, 4'h0);
    cmp(ld, 16'h0100);
    cmp(pe, 1'b0);
    run(32'h040);
    cmp(la, 4'h2);
    $display("wrap test done");
    close_out();
  end
endmodule : tb_top
